// File: src/btr_regs.sv
`timescale 1ns/10ps
module btr_regs
    import btr_pkg::*;
#(
    parameter int SLOW_DIV = CAL_SLOW_CYC
)
(
    // clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst_b,
    // register access from the control port
    input  wire logic [6:0]  i_reg_addr,
    input  wire logic        i_reg_wr,
    input  wire logic [7:0]  i_reg_wdata,
    output logic      [7:0]  o_reg_rdata,
    // test bus
    input  wire logic [4:0]  i_test_bus_addr,
    input  wire logic [7:0]  i_test_sel_data,
    input  wire logic [7:0]  i_hr_xor_data,
    output logic      [4:0]  o_test_bus_addr,
    output logic      [7:0]  o_test_bus,
    output logic      [8:0]  o_pn_fault,
    // timing and calibration
    output logic             o_jump_clk_en,
    input  wire logic [4:0]  i_cal_direct,
    input  wire logic [4:0]  i_cal_loop,
    output logic      [4:0]  o_cal_bits,
    // converters and loopback
    input  wire logic [5:0]  i_adc_rssi,
    input  wire logic [2:0]  i_adc_i,
    input  wire logic [2:0]  i_adc_q,
    input  wire logic [2:0]  i_tx_i,
    input  wire logic [2:0]  i_tx_q,
    output logic      [11:0] o_adc_pins,
    output logic             o_modem_en,
    output logic      [2:0]  o_rx_i,
    output logic      [2:0]  o_rx_q,
    // receive control
    input  wire logic        i_demod_data_ready,
    output logic             o_cck_sel,
    output logic             o_cck_odd_rot,
    output logic             o_qpsk_acq,
    output logic             o_energy_detect_en,
    output logic             o_raw_cca_sel
);
    logic [7:0]  test_mode;
    logic [7:0]  rx_ctrl;
    logic [8:0]  pn;
    logic [7:0]  next_test_mode;
    logic [7:0]  next_rx_ctrl;
    logic [7:0]  next_rdata;
    logic [8:0]  next_pn;
    logic        cal_tick;
    logic [CAL_CNT_W-1:0] fast_gap;
    logic [CAL_CNT_W-1:0] next_fast_gap;

    btr_cal_tick #(
        .SLOW_DIV (SLOW_DIV),
        .FAST_DIV (CAL_FAST_CYC)
    ) u_tick (
        .i_ref_clk (i_ref_clk),
        .i_rst_b   (i_rst_b),
        .i_fast    (test_mode[TM_FAST_CAL_BIT]),
        .o_tick    (cal_tick)
    );

    // register file
    always_comb
    begin
        next_test_mode = test_mode;
        next_rx_ctrl   = rx_ctrl;
        if (i_reg_wr && i_reg_addr == TEST_MODE_OFS)
        begin
            next_test_mode = i_reg_wdata;
        end
        else if (i_reg_wr && i_reg_addr == RX_CTRL_OFS)
        begin
            next_rx_ctrl = i_reg_wdata;
        end
        if (i_reg_addr == TEST_MON_OFS)
        begin
            next_rdata = o_test_bus;
        end
        else if (i_reg_addr == TEST_MODE_OFS)
        begin
            next_rdata = test_mode;
        end
        else if (i_reg_addr == RX_CTRL_OFS)
        begin
            next_rdata = rx_ctrl;
        end
        else
        begin
            next_rdata = 8'h00;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_b)
        begin
            test_mode   <= TEST_MODE_RST;
            rx_ctrl     <= RX_CTRL_RST;
            o_reg_rdata <= 8'h00;
        end
        else
        begin
            test_mode   <= next_test_mode;
            rx_ctrl     <= next_rx_ctrl;
            o_reg_rdata <= next_rdata;
        end
    end

    // fault-test generator, x^9 + x^5 + 1
    always_comb
    begin
        next_pn = pn;
        if (test_mode[TM_PN_FAULT_BIT])
        begin
            next_pn = {pn[7:0], pn[8] ^ pn[4]};
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_b)
        begin
            pn <= PN_SEED;
        end
        else
        begin
            pn <= next_pn;
        end
    end

    // datapath selects, all registered
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_b)
        begin
            o_test_bus_addr    <= 5'h00;
            o_test_bus         <= 8'h00;
            o_pn_fault         <= 9'h000;
            o_jump_clk_en      <= 1'b1;
            o_cal_bits         <= 5'h00;
            o_adc_pins         <= 12'h000;
            o_modem_en         <= 1'b1;
            o_rx_i             <= 3'h0;
            o_rx_q             <= 3'h0;
            o_cck_sel          <= 1'b0;
            o_cck_odd_rot      <= 1'b0;
            o_qpsk_acq         <= 1'b0;
            o_energy_detect_en <= 1'b1;
            o_raw_cca_sel      <= 1'b0;
        end
        else
        begin
            o_pn_fault <= test_mode[TM_PN_FAULT_BIT] ? pn : 9'h000;
            o_jump_clk_en <= !test_mode[TM_JMPCLK_OFF_BIT];
            o_test_bus <= test_mode[TM_HR_XOR_BIT] ? i_hr_xor_data
                                                   : i_test_sel_data;
            o_test_bus_addr <= test_mode[TM_RAND_ADDR_BIT] ? pn[4:0]
                                                           : i_test_bus_addr;
            if (test_mode[TM_CAL_DIRECT_BIT])
            begin
                o_cal_bits <= i_cal_direct;
            end
            else if (cal_tick)
            begin
                o_cal_bits <= i_cal_loop;
            end
            o_adc_pins <= test_mode[TM_ADC_TEST_BIT] ? {i_adc_rssi, i_adc_i, i_adc_q}
                                                     : 12'h000;
            o_modem_en <= !test_mode[TM_ADC_TEST_BIT];
            o_rx_i <= test_mode[TM_LOOPBACK_BIT] ? i_tx_i : i_adc_i;
            o_rx_q <= test_mode[TM_LOOPBACK_BIT] ? i_tx_q : i_adc_q;
            o_cck_sel          <= rx_ctrl[RC_CCK_SEL_BIT];
            o_cck_odd_rot      <= rx_ctrl[RC_CCK_ROT_BIT];
            o_qpsk_acq         <= rx_ctrl[RC_QPSK_ACQ_BIT];
            o_energy_detect_en <= rx_ctrl[RC_ED_CONT_BIT] || !i_demod_data_ready;
            o_raw_cca_sel      <= rx_ctrl[RC_RAW_CCA_BIT];
        end
    end

    // checks
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);

    // cycles since the last calibration tick while the fast rate is on
    always_comb
    begin
        next_fast_gap = fast_gap + CAL_CNT_W'(1);
        if (cal_tick || !test_mode[TM_FAST_CAL_BIT])
        begin
            next_fast_gap = '0;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_b)
        begin
            fast_gap <= '0;
        end
        else
        begin
            fast_gap <= next_fast_gap;
        end
    end

    AST_PN_RUNS: assert property (
        test_mode[TM_PN_FAULT_BIT] && $past(test_mode[TM_PN_FAULT_BIT])
        |-> pn == {$past(pn[7:0]), $past(pn[8]) ^ $past(pn[4])})
        else $error("fault-test generator did not step");

    AST_JUMP_CLK: assert property (
        ##1 o_jump_clk_en == !$past(test_mode[TM_JMPCLK_OFF_BIT]))
        else $error("jump clock enable wrong");

    AST_HR_XOR: assert property (
        test_mode[TM_HR_XOR_BIT]
        |=> o_test_bus == $past(i_hr_xor_data))
        else $error("test bus not carrying xor data");

    AST_RAND_ADDR: assert property (
        !test_mode[TM_RAND_ADDR_BIT]
        |=> o_test_bus_addr == $past(i_test_bus_addr))
        else $error("test bus address not passed through");

    AST_CAL_DIRECT: assert property (
        test_mode[TM_CAL_DIRECT_BIT]
        |=> o_cal_bits == $past(i_cal_direct))
        else $error("cal bits not direct");

    AST_CAL_HOLD: assert property (
        !test_mode[TM_CAL_DIRECT_BIT] && !cal_tick
        |=> $stable(o_cal_bits))
        else $error("cal bits changed without tick");

    AST_FAST_TICK: assert property (
        test_mode[TM_FAST_CAL_BIT]
        |-> fast_gap < CAL_CNT_W'(CAL_FAST_CYC))
        else $error("fast calibration tick missing");

    AST_ADC_TEST: assert property (
        test_mode[TM_ADC_TEST_BIT]
        |=> !o_modem_en && o_adc_pins == {$past(i_adc_rssi), $past(i_adc_i), $past(i_adc_q)})
        else $error("converter test mode wrong");

    AST_LOOPBACK: assert property (
        test_mode[TM_LOOPBACK_BIT]
        |=> o_rx_i == $past(i_tx_i) && o_rx_q == $past(i_tx_q))
        else $error("loopback not applied");

    AST_RX_WRITE: assert property (
        i_reg_wr && i_reg_addr == RX_CTRL_OFS
        |=> rx_ctrl == $past(i_reg_wdata)
        ##1 o_cck_sel == $past(rx_ctrl[RC_CCK_SEL_BIT])
        && o_cck_odd_rot == $past(rx_ctrl[RC_CCK_ROT_BIT])
        && o_qpsk_acq == $past(rx_ctrl[RC_QPSK_ACQ_BIT])
        && o_raw_cca_sel == $past(rx_ctrl[RC_RAW_CCA_BIT]))
        else $error("receive control write not applied");

    AST_ED_STOP: assert property (
        !rx_ctrl[RC_ED_CONT_BIT] && i_demod_data_ready
        |=> !o_energy_detect_en)
        else $error("energy detect not stopped");

    AST_MON_READ: assert property (
        i_reg_addr == TEST_MON_OFS
        |=> o_reg_rdata == $past(o_test_bus))
        else $error("monitor read wrong");

    AST_MON_RO: assert property (
        i_reg_wr && i_reg_addr == TEST_MON_OFS
        |=> test_mode == $past(test_mode) && rx_ctrl == $past(rx_ctrl))
        else $error("monitor write changed a register");

    AST_RESET: assert property (
        disable iff (1'b0) !i_rst_b
        |=> test_mode == 8'h00 && rx_ctrl == 8'h00)
        else $error("registers not cleared by reset");

    COV_LOOPBACK: cover property (test_mode[TM_LOOPBACK_BIT] ##1 o_rx_i != i_adc_i);
    COV_FAST_CAL: cover property (test_mode[TM_FAST_CAL_BIT] && cal_tick);
    COV_ED_STOP: cover property (!rx_ctrl[RC_ED_CONT_BIT] && i_demod_data_ready);
    COV_MON_READ: cover property (i_reg_addr == TEST_MON_OFS && o_test_bus != 8'h00);
endmodule // btr_regs

// File: src/btr_pkg.sv
package btr_pkg;
    // register offsets on the control port
    localparam logic [6:0] TEST_MON_OFS      = 7'h74;
    localparam logic [6:0] TEST_MODE_OFS     = 7'h78;
    localparam logic [6:0] RX_CTRL_OFS       = 7'h7C;

    // reset values
    localparam logic [7:0] TEST_MODE_RST     = 8'h00;
    localparam logic [7:0] RX_CTRL_RST       = 8'h00;
    localparam logic [8:0] PN_SEED           = 9'h1FF;

    // test_mode_control fields
    localparam int TM_PN_FAULT_BIT           = 7;
    localparam int TM_JMPCLK_OFF_BIT         = 6;
    localparam int TM_HR_XOR_BIT             = 5;
    localparam int TM_RAND_ADDR_BIT          = 4;
    localparam int TM_FAST_CAL_BIT           = 3;
    localparam int TM_CAL_DIRECT_BIT         = 2;
    localparam int TM_ADC_TEST_BIT           = 1;
    localparam int TM_LOOPBACK_BIT           = 0;

    // receive_control fields
    localparam int RC_SPARE_MSB              = 7;
    localparam int RC_SPARE_LSB              = 5;
    localparam int RC_CCK_SEL_BIT            = 4;
    localparam int RC_CCK_ROT_BIT            = 3;
    localparam int RC_QPSK_ACQ_BIT           = 2;
    localparam int RC_ED_CONT_BIT            = 1;
    localparam int RC_RAW_CCA_BIT            = 0;

    // calibration tick timing
    localparam int REF_CLK_HZ                = 25_000_000;
    localparam int CAL_SLOW_HZ               = 1_000;
    localparam int CAL_FAST_HZ               = 22_000;
    localparam int CAL_SLOW_CYC              = REF_CLK_HZ / CAL_SLOW_HZ;
    localparam int CAL_FAST_CYC              = REF_CLK_HZ / CAL_FAST_HZ;
    localparam int CAL_CNT_W                 = 15;
endpackage

// File: src/btr_cal_tick.sv
`timescale 1ns/10ps
module btr_cal_tick
    import btr_pkg::*;
#(
    parameter int SLOW_DIV = CAL_SLOW_CYC,
    parameter int FAST_DIV = CAL_FAST_CYC
)
(
    // clock and reset
    input  wire logic i_ref_clk,
    input  wire logic i_rst_b,
    // rate select
    input  wire logic i_fast,
    // tick out
    output logic      o_tick
);
    logic [CAL_CNT_W-1:0] cnt;
    logic [CAL_CNT_W-1:0] next_cnt;
    logic                 next_tick;
    logic [CAL_CNT_W-1:0] limit;

    always_comb
    begin
        limit     = i_fast ? CAL_CNT_W'(FAST_DIV - 1) : CAL_CNT_W'(SLOW_DIV - 1);
        next_tick = 1'b0;
        next_cnt  = cnt + CAL_CNT_W'(1);
        if (cnt >= limit)
        begin
            next_cnt  = '0;
            next_tick = 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_b)
        begin
            cnt    <= '0;
            o_tick <= 1'b0;
        end
        else
        begin
            cnt    <= next_cnt;
            o_tick <= next_tick;
        end
    end
endmodule // btr_cal_tick

// File: tb/tb_top.sv
`timescale 1ns/10ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_errors++; \
    $display("ERROR %0t got %0h exp %0h", $time, (got), (exp)); end end
module tb_top
    import btr_pkg::*;
;
    localparam int SDIV = 50;
    logic        i_ref_clk = 1'b0;
    logic        i_rst_b = 1'b0;
    logic [6:0]  i_reg_addr = 7'h00;
    logic        i_reg_wr = 1'b0;
    logic [7:0]  i_reg_wdata = 8'h00;
    logic [7:0]  o_reg_rdata;
    logic [4:0]  i_test_bus_addr = 5'h11;
    logic [7:0]  i_test_sel_data = 8'h5A;
    logic [7:0]  i_hr_xor_data = 8'hC3;
    logic [4:0]  o_test_bus_addr;
    logic [7:0]  o_test_bus;
    logic [8:0]  o_pn_fault;
    logic        o_jump_clk_en;
    logic [4:0]  i_cal_direct = 5'h15;
    logic [4:0]  i_cal_loop = 5'h0A;
    logic [4:0]  o_cal_bits;
    logic [5:0]  i_adc_rssi = 6'h2A;
    logic [2:0]  i_adc_i = 3'h5;
    logic [2:0]  i_adc_q = 3'h2;
    logic [2:0]  i_tx_i = 3'h3;
    logic [2:0]  i_tx_q = 3'h6;
    logic [11:0] o_adc_pins;
    logic        o_modem_en;
    logic [2:0]  o_rx_i;
    logic [2:0]  o_rx_q;
    logic        i_demod_data_ready = 1'b0;
    logic        o_cck_sel;
    logic        o_cck_odd_rot;
    logic        o_qpsk_acq;
    logic        o_energy_detect_en;
    logic        o_raw_cca_sel;
    int          n_errors = 0;
    int          samples_checked = 0;

    btr_regs #(.SLOW_DIV(SDIV)) dut (
        .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_reg_addr(i_reg_addr),
        .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
        .i_test_bus_addr(i_test_bus_addr), .i_test_sel_data(i_test_sel_data),
        .i_hr_xor_data(i_hr_xor_data), .o_test_bus_addr(o_test_bus_addr),
        .o_test_bus(o_test_bus), .o_pn_fault(o_pn_fault), .o_jump_clk_en(o_jump_clk_en),
        .i_cal_direct(i_cal_direct), .i_cal_loop(i_cal_loop), .o_cal_bits(o_cal_bits),
        .i_adc_rssi(i_adc_rssi), .i_adc_i(i_adc_i), .i_adc_q(i_adc_q), .i_tx_i(i_tx_i),
        .i_tx_q(i_tx_q), .o_adc_pins(o_adc_pins), .o_modem_en(o_modem_en),
        .o_rx_i(o_rx_i), .o_rx_q(o_rx_q), .i_demod_data_ready(i_demod_data_ready),
        .o_cck_sel(o_cck_sel), .o_cck_odd_rot(o_cck_odd_rot), .o_qpsk_acq(o_qpsk_acq),
        .o_energy_detect_en(o_energy_detect_en), .o_raw_cca_sel(o_raw_cca_sel)
    );

    initial
    begin
        forever #20 i_ref_clk = ~i_ref_clk;
    end

    task automatic idle(input int n);
        repeat (n) @(negedge i_ref_clk);
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        i_reg_addr = a;
        i_reg_wdata = d;
        i_reg_wr = 1'b1;
        @(negedge i_ref_clk);
        i_reg_wr = 1'b0;
        @(negedge i_ref_clk);
    endtask

    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        i_reg_addr = a;
        @(negedge i_ref_clk);
        `CHK(o_reg_rdata, e)
    endtask

    // test-mode outputs against the mode byte just written; cal bits only in direct mode, pn output and bus address only when off
    task automatic check_tm(input logic [7:0] m);
        wr(TEST_MODE_OFS, m);
        idle(2);
        `CHK(o_jump_clk_en, ~m[6])
        `CHK(o_modem_en, ~m[1])
        `CHK(o_adc_pins, m[1] ? {i_adc_rssi, i_adc_i, i_adc_q} : 12'h000)
        `CHK(o_rx_i, m[0] ? i_tx_i : i_adc_i)
        `CHK(o_rx_q, m[0] ? i_tx_q : i_adc_q)
        `CHK(o_test_bus, m[5] ? i_hr_xor_data : i_test_sel_data)
        if (m[2]) `CHK(o_cal_bits, i_cal_direct)
        if (!m[7]) `CHK(o_pn_fault, 9'h000)
        if (!m[4]) `CHK(o_test_bus_addr, i_test_bus_addr)
        rd(TEST_MON_OFS, m[5] ? i_hr_xor_data : i_test_sel_data);
        rd(TEST_MODE_OFS, m);
    endtask

    task automatic check_rc(input logic [7:0] m, input logic dr);
        i_demod_data_ready = dr;
        wr(RX_CTRL_OFS, m);
        idle(2);
        `CHK(o_cck_sel, m[4])
        `CHK(o_cck_odd_rot, m[3])
        `CHK(o_qpsk_acq, m[2])
        `CHK(o_raw_cca_sel, m[0])
        `CHK(o_energy_detect_en, m[1] | ~dr)
        rd(RX_CTRL_OFS, m);
    endtask

    // gap between two loop-bit updates of the calibration output
    task automatic cal_period(input int exp_cyc);
        int n;
        begin
            for (int k = 0; k < 3; k++)
            begin
                i_cal_loop = ~i_cal_loop;
                n = 0;
                while (o_cal_bits !== i_cal_loop && n < 3000)
                begin
                    idle(1);
                    n++;
                end
            end
            `CHK(n >= exp_cyc - 2 && n <= exp_cyc + 2, 1'b1)
        end
    endtask

    task automatic report_and_stop();
        $display("checked %0d, errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge i_ref_clk);
        n_errors++;
        report_and_stop();
    end

    initial
    begin
        logic [4:0] a0;
        idle(4);
        i_rst_b = 1'b1;
        idle(1);
        `CHK({o_jump_clk_en, o_modem_en, o_energy_detect_en}, 3'b111)
        `CHK({o_pn_fault, o_adc_pins}, 21'h00000)
        rd(TEST_MODE_OFS, TEST_MODE_RST);
        rd(RX_CTRL_OFS, RX_CTRL_RST);
        $display("test reset done");
        for (int i = 0; i < 8; i++)
            check_tm(8'h01 << i);
        check_tm(8'h27);
        check_tm(8'h90);
        a0 = o_test_bus_addr;
        for (int k = 0; k < 6 && o_test_bus_addr === a0; k++)
            idle(1);
        `CHK(o_test_bus_addr != a0, 1'b1)
        `CHK(o_pn_fault != 9'h000, 1'b1)
        $display("test mode done");
        wr(TEST_MODE_OFS, 8'h00);
        cal_period(SDIV);
        wr(TEST_MODE_OFS, 8'h08);
        cal_period(CAL_FAST_CYC);
        $display("test calibration done");
        for (int i = 0; i < 8; i++)
            check_rc(8'h01 << i, i[0]);
        check_rc(8'h00, 1'b1);
        $display("test receive done");
        wr(7'h00, 8'hFF);
        wr(TEST_MON_OFS, 8'hFF);
        rd(7'h00, 8'h00);
        rd(TEST_MODE_OFS, 8'h08);
        rd(TEST_MON_OFS, i_test_sel_data);
        $display("test unmapped done");
        report_and_stop();
    end
endmodule // tb_top
